// *** logic/fma_top.sv ***
// Purpose: flash memory accelerator between core local bus and one flash bank
// Assumes: all inputs come from logic on the same clock; core holds a request until served
// Notes:   core_wait_clock_gate low stalls the core; read data follows one cycle later

`timescale 1ns/1ps
`default_nettype none

module fma_top (
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    // core local bus
    input  wire logic                        core_req,
    input  wire logic [fma_pkg::ADDR_W-1:0]  core_addr,
    input  wire logic                        core_seq,
    input  wire logic [fma_pkg::PROT_W-1:0]  access_protection_bits,
    output logic                             core_wait_clock_gate,
    output logic                             core_rvalid,
    output logic [fma_pkg::WORD_W-1:0]       core_rdata,
    // configuration levels
    input  wire logic [fma_pkg::MODE_W-1:0]  accelerator_mode_control,
    input  wire logic [fma_pkg::CNT_W-1:0]   flash_fetch_cycle_count,
    // flash bank
    output logic                             flash_rd_start,
    output logic [fma_pkg::TAG_W-1:0]        flash_line_addr,
    input  wire logic [fma_pkg::LINE_W-1:0]  flash_rdata,
    input  wire logic                        flash_busy,
    input  wire logic                        flash_prog_start
);
    import fma_pkg::*;

    // read sequencer state
    fma_state_type           state;
    fma_kind_type            rd_kind;
    logic [CNT_W-1:0]        cnt;
    logic [BUF_IDX_W-1:0]    rd_dest;

    // line buffers with their address latches
    logic [LINE_W-1:0]       buf_line [NBUF];
    logic [TAG_W-1:0]        buf_tag  [NBUF];
    logic [NBUF-1:0]         buf_valid;
    logic [NBUF-1:0]         fresh;

    // prefetched line held at the flash output
    logic [LINE_W-1:0]       ph_line;
    logic [TAG_W-1:0]        ph_tag;
    logic                    ph_valid;

    // instruction flash address latch and mode copy
    logic [TAG_W-1:0]        ilatch;
    logic                    ilatch_valid;
    logic [MODE_W-1:0]       mode;

    // decode of the current request
    logic                    is_instr;
    logic [TAG_W-1:0]        req_line;
    logic [WSEL_W-1:0]       req_sel;
    logic                    mode_on;
    logic                    mode_full;
    logic                    mode_part;
    logic                    code_hit_ok;
    logic                    inval;
    logic [CNT_W-1:0]        fetch_len;
    logic                    reading;
    logic                    read_done;
    logic [NBUF-1:0]         match;
    logic [NBUF-1:0]         allow;
    logic                    hit_any;
    logic [BUF_IDX_W-1:0]    hit_idx;
    logic                    ph_take;
    logic                    serve;
    logic                    inflight_match;
    logic                    need_read;
    logic                    flash_free;
    logic                    demand_start;
    logic [BUF_IDX_W-1:0]    dest_idx;
    logic [TAG_W-1:0]        pf_target;
    logic                    pf_have;
    logic                    pf_start;

    // address latch compare used for every buffer and the held line
    function automatic logic line_hit(
        input logic             v,
        input logic [TAG_W-1:0] tag,
        input logic [TAG_W-1:0] line
    );
        line_hit = v && (tag == line);
    endfunction

    // word multiplexer: one 4:1 choice per bit of the 32-bit word
    function automatic logic [WORD_W-1:0] word_pick(
        input logic [LINE_W-1:0] line,
        input logic [WSEL_W-1:0] sel
    );
        word_pick = '0;
        for (int w = 0; w < WORDS; w++) begin
            if (sel == WSEL_W'(w)) begin
                word_pick = line[w*WORD_W +: WORD_W];
            end
        end
    endfunction

    // request decode; protection bit 0 set marks a data access
    assign is_instr  = !access_protection_bits[PROT_DATA_BIT];
    assign req_line  = core_addr[ADDR_W-1:OFF_BITS];
    assign req_sel   = core_addr[WSEL_LSB +: WSEL_W];

    // mode decode; the reserved code behaves as off
    assign mode_full = (mode == MODE_FULL);
    assign mode_part = (mode == MODE_PART);
    assign mode_on   = mode_full || mode_part;
    assign code_hit_ok = is_instr && (mode_full || (mode_part && core_seq));

    // program start or mode change wipes every buffer
    assign inval = flash_prog_start || (mode != accelerator_mode_control);

    // zero count is reserved; treat it as the shortest read
    assign fetch_len = (flash_fetch_cycle_count == CNT_ZERO) ? CNT_ONE : flash_fetch_cycle_count;
    assign reading   = (state == ST_READ);
    assign read_done = reading && (cnt >= fetch_len);

    // one comparator per buffer, gated by kind and mode
    for (genvar g = 0; g < NBUF; g++) begin : g_cmp
        assign match[g] = line_hit(buf_valid[g], buf_tag[g], req_line);
        assign allow[g] = (is_instr ? (g != BUF_DT) : (g == BUF_DT)) &&
                          (fresh[g] || ((g == BUF_DT) ? mode_full : code_hit_ok));
    end

    // lowest index wins when two buffers hold the line
    always_comb begin
        hit_any = 1'h0;
        hit_idx = BUF_PF;
        for (int i = NBUF - 1; i >= 0; i--) begin
            if (match[i] && allow[i]) begin
                hit_any = 1'h1;
                hit_idx = BUF_IDX_W'(i);
            end
        end
    end

    // held prefetch is taken only for its own line
    assign ph_take = core_req && !flash_busy && !hit_any && code_hit_ok &&
                     line_hit(ph_valid, ph_tag, req_line);
    // nothing is served from a buffer in the cycle that wipes it
    assign serve   = core_req && !flash_busy && !inval && (hit_any || ph_take);

    // stall whenever the request cannot be served now; busy flash always stalls
    assign core_wait_clock_gate = !core_req || serve;

    // a read already fetching this line is waited for, not repeated
    always_comb begin
        inflight_match = 1'h0;
        if (reading && (flash_line_addr == req_line)) begin
            if (rd_kind == RK_PREFETCH) begin
                inflight_match = is_instr;
            end else begin
                inflight_match = ((rd_dest != BUF_DT) == is_instr);
            end
        end
    end

    assign need_read  = core_req && !flash_busy && !serve && !inflight_match;
    // a demand read may cut off a running prefetch
    assign flash_free = !reading || read_done || (rd_kind == RK_PREFETCH);
    assign demand_start = need_read && flash_free && !inval;

    // sequential fetches fill the prefetch buffer, branches the branch trail buffer
    assign dest_idx = !is_instr ? BUF_DT : (core_seq ? BUF_PF : BUF_BT);

    // prefetch target follows the address latch, or the line being served now
    assign pf_target = (serve && is_instr) ? req_line + TAG_ONE : ilatch + TAG_ONE;
    assign pf_have   = line_hit(buf_valid[BUF_PF], buf_tag[BUF_PF], pf_target) ||
                       (line_hit(ph_valid, ph_tag, pf_target) && !ph_take) ||
                       (read_done && (rd_kind == RK_PREFETCH) && (flash_line_addr == pf_target));
    // an aborted prefetch comes back here once the data read is done
    assign pf_start  = mode_on && ilatch_valid && !need_read && !pf_have && !flash_busy &&
                       !inval && (!reading || read_done);

    // read sequencer: counts the programmed clocks of each flash line read
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state           <= ST_IDLE;
            rd_kind         <= RK_DEMAND;
            rd_dest         <= BUF_PF;
            cnt             <= CNT_ONE;
            flash_line_addr <= '0;
            flash_rd_start  <= 1'h0;
        end else begin
            flash_rd_start <= demand_start || pf_start;
            if (inval) begin
                state <= ST_IDLE;
            end else if (demand_start) begin
                state           <= ST_READ;
                cnt             <= CNT_ONE;
                rd_kind         <= RK_DEMAND;
                rd_dest         <= dest_idx;
                flash_line_addr <= req_line;
            end else if (pf_start) begin
                state           <= ST_READ;
                cnt             <= CNT_ONE;
                rd_kind         <= RK_PREFETCH;
                flash_line_addr <= pf_target;
            end else if (read_done) begin
                state <= ST_IDLE;
            end else if (reading) begin
                cnt <= cnt + CNT_ONE;
            end
        end
    end

    // buffer contents, valid flags and the held prefetch line
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            buf_valid <= '0;
            fresh     <= '0;
            ph_valid  <= 1'h0;
            ph_line   <= '0;
            ph_tag    <= '0;
            for (int i = 0; i < NBUF; i++) begin
                buf_line[i] <= '0;
                buf_tag[i]  <= '0;
            end
        end else if (inval) begin
            buf_valid <= '0;
            fresh     <= '0;
            ph_valid  <= 1'h0;
        end else begin
            // a fresh line serves its one waiting request, even when mode forbids hits
            if (serve) begin
                fresh <= '0;
            end
            if (ph_take) begin
                buf_line[BUF_PF]  <= ph_line;
                buf_tag[BUF_PF]   <= ph_tag;
                buf_valid[BUF_PF] <= 1'h1;
                ph_valid          <= 1'h0;
            end else if (demand_start && is_instr) begin
                ph_valid <= 1'h0;
            end
            if (read_done && (rd_kind == RK_PREFETCH)) begin
                ph_line  <= flash_rdata;
                ph_tag   <= flash_line_addr;
                ph_valid <= 1'h1;
            end
            if (read_done && (rd_kind == RK_DEMAND)) begin
                buf_line[rd_dest]  <= flash_rdata;
                buf_tag[rd_dest]   <= flash_line_addr;
                buf_valid[rd_dest] <= 1'h1;
                fresh[rd_dest]     <= 1'h1;
            end
        end
    end

    // instruction address latch feeding the prefetch incrementer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ilatch       <= '0;
            ilatch_valid <= 1'h0;
        end else if (inval) begin
            ilatch_valid <= 1'h0;
        end else if (serve && is_instr) begin
            ilatch       <= req_line;
            ilatch_valid <= 1'h1;
        end
    end

    // mode copy; a difference from the input is the change event
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mode <= MODE_RESET;
        end else begin
            mode <= accelerator_mode_control;
        end
    end

    // returned word registered so the core sees flop outputs
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            core_rvalid <= 1'h0;
            core_rdata  <= '0;
        end else begin
            core_rvalid <= serve;
            if (serve) begin
                core_rdata <= ph_take ? word_pick(ph_line, req_sel)
                                      : word_pick(buf_line[hit_idx], req_sel);
            end
        end
    end

    // helper: clocks spent in the current read, counted independently
    // it lags by one: from the second clock of a read on, in the n-th clock it holds n-1
    logic [CNT_W-1:0] chk_age;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            chk_age <= CNT_ZERO;
        end else if (flash_rd_start) begin
            chk_age <= CNT_ONE;
        end else if (reading) begin
            chk_age <= chk_age + CNT_ONE;
        end
    end

    default clocking chk_clk @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_busy_stall: assert property (core_req && flash_busy |-> !core_wait_clock_gate)
        else $error("core not stalled while flash busy");
    chk_prog_inval: assert property (flash_prog_start |=> (buf_valid == '0) && !ph_valid)
        else $error("buffers still valid after program start");
    chk_mode_inval: assert property (mode != accelerator_mode_control |=> buf_valid == '0)
        else $error("buffers still valid after mode change");
    chk_read_len: assert property (read_done
        |-> (flash_rd_start ? CNT_ONE : chk_age + CNT_ONE) == fetch_len)
        else $error("flash read length differs from programmed count");
    chk_data_prio: assert property (need_read && reading && rd_kind == RK_PREFETCH && !inval
        |=> flash_rd_start && rd_kind == RK_DEMAND)
        else $error("demand read did not preempt prefetch");
    chk_data_route: assert property (serve && !is_instr |-> hit_idx == BUF_DT && !ph_take)
        else $error("data access served from an instruction buffer");
    chk_off_noprefetch: assert property (mode != MODE_PART && mode != MODE_FULL |-> !pf_start)
        else $error("prefetch started while accelerator off");
    chk_demand_fill: assert property (read_done && rd_kind == RK_DEMAND && !inval
        |=> buf_valid[$past(rd_dest)] && buf_tag[$past(rd_dest)] == $past(flash_line_addr))
        else $error("demand line not stored in its buffer");
    chk_held_load: assert property (ph_take |=> buf_valid[BUF_PF] && buf_tag[BUF_PF] == $past(req_line))
        else $error("held prefetch not moved into prefetch buffer");
    chk_rdata_follow: assert property (serve |=> core_rvalid ##1 !core_rvalid || $past(serve))
        else $error("read data valid not paired with a served request");
    // no read may start while the bank programs; an instruction miss drops the held line
    chk_idle_busy: assert property (flash_busy && !flash_prog_start
        |-> !flash_rd_start)
        else $error("flash read started while flash busy");
    chk_held_drop: assert property (demand_start && is_instr
        && !(read_done && rd_kind == RK_PREFETCH) |=> !ph_valid)
        else $error("held prefetch kept after an instruction miss");

    cov_held_take:    cover property (ph_take ##1 core_rvalid);
    cov_prefetch_cut: cover property (demand_start && reading && rd_kind == RK_PREFETCH);
    cov_branch_hit:   cover property (serve && is_instr && hit_idx == BUF_BT);
    cov_busy_wait:    cover property ((core_req && flash_busy) [*3] ##1 core_req && !flash_busy);

endmodule

`default_nettype wire

// *** logic/fma_pkg.sv ***
// Purpose: shared constants and types for the flash memory accelerator
// Assumes: 19-bit byte address into one flash bank, 16-byte lines
// Notes:   every number the logic uses is named here
//
// How it works
// - three 128-bit line buffers: prefetch, branch trail, data.
// - instruction miss with no matching prefetch stalls core and reads whole line.
// - request for a line already being prefetched waits only for that prefetch.
// - next sequential prefetch starts once flash is free, from incremented address latch.
// - prefetched line enters prefetch buffer only when core asks; otherwise discarded.
// - requested word picked from the line by 4:1 word multiplexers per buffer.
// - protection bit 0 splits instruction from data; each uses its own buffers.
// - data access crossing into a new line reads flash, aborting any prefetch.
// - an aborted prefetch is started again after the data read ends.
// - non-sequential fetch target captured in branch trail buffer, later served from it.
// - branch to unbuffered line stalls core while branch trail buffer loads.
// - each buffer has a 15-bit line address latch and comparator deciding hits.
// - data miss reads the full four-word line into the data buffer.
// - while flash programs or erases, any core access is held by wait control.
// - start of program or erase invalidates every buffer.
// - sequential code runs stall-free when clock period is at least a third of access time.
// - two-bit mode: 00 off, 01 partial, 10 full, 11 reserved; reset selects off.
// - partial serves sequential code hits only; full serves all code and data hits.
// - any change of mode invalidates all buffers.
// - flash read lasts exactly the programmed one to seven clocks.

`default_nettype none

package fma_pkg;

    // widths of the data path
    localparam int LINE_W    = 128;
    localparam int WORD_W    = 32;
    localparam int WORDS     = 4;
    localparam int WSEL_W    = 2;
    localparam int WSEL_LSB  = 2;
    localparam int TAG_W     = 15;
    localparam int OFF_BITS  = 4;
    localparam int ADDR_W    = TAG_W + OFF_BITS;
    localparam int PROT_W    = 2;
    localparam int PROT_DATA_BIT = 0;

    // buffer indices
    localparam int NBUF      = 3;
    localparam int BUF_IDX_W = 2;
    localparam logic [BUF_IDX_W-1:0] BUF_PF = 2'h0;
    localparam logic [BUF_IDX_W-1:0] BUF_BT = 2'h1;
    localparam logic [BUF_IDX_W-1:0] BUF_DT = 2'h2;

    // operating modes
    localparam int MODE_W = 2;
    localparam logic [MODE_W-1:0] MODE_OFF   = 2'h0;
    localparam logic [MODE_W-1:0] MODE_PART  = 2'h1;
    localparam logic [MODE_W-1:0] MODE_FULL  = 2'h2;
    localparam logic [MODE_W-1:0] MODE_RESET = MODE_OFF;

    // read timing
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
    localparam logic [CNT_W-1:0] CNT_ONE  = 3'h1;
    localparam logic [TAG_W-1:0] TAG_ONE  = 15'h0001;

    typedef enum logic {ST_IDLE, ST_READ} fma_state_type;
    typedef enum logic {RK_DEMAND, RK_PREFETCH} fma_kind_type;

endpackage

`default_nettype wire

// *** bench/fma_flash_model.sv ***
// Purpose: behavioural flash bank facing the accelerator
// Assumes: one line read at a time, its length set by the fetch count
// Notes:   data lines carry a moving pattern outside the last read cycle
`timescale 1ns/1ps
`default_nettype none

module fma_flash_model #(
    parameter int BUSY_CYCLES = 6
) (
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    // read side
    input  wire logic                        flash_rd_start,
    input  wire logic [fma_pkg::TAG_W-1:0]   flash_line_addr,
    input  wire logic [fma_pkg::CNT_W-1:0]   flash_fetch_cycle_count,
    output logic      [fma_pkg::LINE_W-1:0]  flash_rdata,
    // program and erase
    input  wire logic                        prog_cmd,
    output logic                             flash_busy,
    output logic                             flash_prog_start
);
    import fma_pkg::*;
    logic [CNT_W-1:0] elapsed;
    logic [CNT_W-1:0] len;
    logic [CNT_W-1:0] cur;
    logic             reading;
    logic [31:0]      noise;
    int               busy_left;

    // count zero reads as one
    assign len = (flash_fetch_cycle_count == CNT_ZERO) ? CNT_ONE : flash_fetch_cycle_count;
    assign cur = flash_rd_start ? CNT_ONE : elapsed + CNT_ONE;
    assign flash_busy = (busy_left != 0);

    // line good only in the last read cycle, so early sampling shows up
    always_comb begin
        flash_rdata = {4{noise}};
        if ((flash_rd_start || reading) && cur == len && !flash_busy) begin
            for (int i = 0; i < WORDS; i++) begin
                flash_rdata[i*WORD_W +: WORD_W] = {1'b1, flash_line_addr, 14'h0, 2'(i)};
            end
        end
    end

    // read progress and a pattern that moves every cycle
    always_ff @(posedge clock) begin
        noise <= noise + 32'h9e3779b9;
        if (!rst_n) begin
            reading <= 1'b0;
            elapsed <= CNT_ZERO;
            noise   <= 32'h5a5ac3c3;
        end else if (flash_rd_start) begin
            reading <= (len > CNT_ONE);
            elapsed <= CNT_ONE;
        end else if (reading) begin
            reading <= (int'(elapsed) + 2 <= int'(len));
            elapsed <= elapsed + CNT_ONE;
        end
    end

    // program/erase: start pulse, then busy for a fixed span
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busy_left        <= 0;
            flash_prog_start <= 1'b0;
        end else begin
            flash_prog_start <= prog_cmd && busy_left == 0;
            if (prog_cmd && busy_left == 0) begin
                busy_left <= BUSY_CYCLES;
            end else if (busy_left != 0) begin
                busy_left <= busy_left - 1;
            end
        end
    end
endmodule

`default_nettype wire

// *** bench/test_flash_memory_accelerator.sv ***
// Purpose: self-checking bench for the flash memory accelerator
// Assumes: inputs move at the falling edge; core holds a request until taken
// Notes:   stall counts are judged against the programmed fetch count
`timescale 1ns/1ps
`default_nettype none

module test_flash_memory_accelerator;
    import fma_pkg::*;
    localparam int BUSY = 6;
    logic              clock;
    logic              rst_n;
    logic              core_req;
    logic [ADDR_W-1:0] core_addr;
    logic              core_seq;
    logic [PROT_W-1:0] access_protection_bits;
    logic              core_wait_clock_gate;
    logic              core_rvalid;
    logic [WORD_W-1:0] core_rdata;
    logic [MODE_W-1:0] accelerator_mode_control;
    logic [CNT_W-1:0]  flash_fetch_cycle_count;
    logic              flash_rd_start;
    logic [TAG_W-1:0]  flash_line_addr;
    logic [LINE_W-1:0] flash_rdata;
    logic              flash_busy;
    logic              flash_prog_start;
    logic              prog_cmd;
    logic [TAG_W-1:0]  tag;
    logic [TAG_W-1:0]  dtag;
    logic [ADDR_W-1:0] a;
    logic [ADDR_W-1:0] last;
    int                c;
    int                miscompares;
    int                n_checks;

    fma_top u_dut (
        .clock, .rst_n, .core_req, .core_addr, .core_seq, .access_protection_bits,
        .core_wait_clock_gate, .core_rvalid, .core_rdata, .accelerator_mode_control,
        .flash_fetch_cycle_count, .flash_rd_start, .flash_line_addr, .flash_rdata,
        .flash_busy, .flash_prog_start
    );
    fma_flash_model #(.BUSY_CYCLES(BUSY)) u_flash (
        .clock, .rst_n, .flash_rd_start, .flash_line_addr, .flash_fetch_cycle_count,
        .flash_rdata, .prog_cmd, .flash_busy, .flash_prog_start
    );

    // 250 MHz clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_range(input string what, input int lo, input int hi, input int got);
        n_checks++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one core access, entered at a falling edge; request left up for the caller
    task automatic expect_stall(input logic [ADDR_W-1:0] ad, input logic s, input logic d,
                                input int lo, input int hi);
        int st;
        st = 0;
        core_req = 1'b1;
        core_addr = ad;
        core_seq = s;
        access_protection_bits = {1'($urandom_range(0, 1)), d};
        #1;
        while (core_wait_clock_gate !== 1'b1 && st < 200) begin
            @(negedge clock);
            st++;
            #1;
        end
        @(negedge clock);
        check_bit("core_rvalid", 1'b1, core_rvalid);
        check_word("core_rdata", {1'b1, ad[ADDR_W-1:OFF_BITS], 14'h0, ad[3:2]}, core_rdata);
        check_range("stall cycles", lo, hi, st);
    endtask

    task automatic idle(input int n);
        core_req = 1'b0;
        repeat (n) @(negedge clock);
    endtask

    task automatic set_mode(input logic [MODE_W-1:0] m);
        accelerator_mode_control = m;
        idle(3);
    endtask

    // a hang ends the run
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        $display("ERROR watchdog expected finish seen hang");
        complete_run();
    end

    initial begin
        miscompares = 0;
        n_checks = 0;
        rst_n = 1'b0;
        core_req = 1'b0;
        core_addr = '0;
        core_seq = 1'b0;
        access_protection_bits = '0;
        accelerator_mode_control = MODE_OFF;
        flash_fetch_cycle_count = 3'h3;
        prog_cmd = 1'b0;
        void'($urandom(16));
        tag = 15'($urandom_range(0, 32767));
        dtag = tag ^ 15'h4000;
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        #1;
        check_bit("idle gate", 1'b1, core_wait_clock_gate);
        check_bit("idle rvalid", 1'b0, core_rvalid);
        @(negedge clock);
        set_mode(MODE_FULL);
        // fetch counts one to seven, code and data paths
        for (c = 1; c <= 7; c++) begin
            // a fresh line group per count, so earlier fills cannot hit
            tag = tag + 15'h10;
            dtag = tag ^ 15'h4000;
            idle(10);
            flash_fetch_cycle_count = 3'(c);
            idle(2);
            expect_stall({tag, 4'h4}, 1'b0, 1'b0, c + 1, c + 1);
            expect_stall({tag, 4'h8}, 1'b1, 1'b0, 0, 0);
            expect_stall({tag, 4'hc}, 1'b1, 1'b0, 0, 0);
            expect_stall({tag + 15'h1, 4'h0}, 1'b1, 1'b0, 0, c);
            idle(10);
            expect_stall({tag, 4'h0}, 1'b0, 1'b0, 0, 0);
            idle(10);
            expect_stall({dtag, 4'h0}, 1'b0, 1'b1, c + 1, c + 1);
            expect_stall({dtag, 4'h4}, 1'b1, 1'b1, 0, 0);
            expect_stall({dtag, 4'hc}, 1'b1, 1'b1, 0, 0);
            expect_stall({dtag + 15'h1, 4'h0}, 1'b1, 1'b1, c + 1, c + 1);
            expect_stall({tag, 4'h4}, 1'b0, 1'b0, 0, 0);
        end
        // partial mode after a mode change
        idle(10);
        c = $urandom_range(1, 7);
        flash_fetch_cycle_count = 3'(c);
        set_mode(MODE_PART);
        expect_stall({tag, 4'h4}, 1'b0, 1'b0, c + 1, c + 1);
        expect_stall({tag, 4'h8}, 1'b1, 1'b0, 0, 0);
        idle(10);
        expect_stall({tag, 4'hc}, 1'b0, 1'b0, c + 1, c + 1);
        idle(10);
        expect_stall({dtag, 4'h0}, 1'b0, 1'b1, c + 1, c + 1);
        idle(10);
        expect_stall({dtag, 4'h4}, 1'b1, 1'b1, c + 1, c + 1);
        // off and the reserved code both read every time
        for (int m = 0; m < 4; m += 3) begin
            set_mode(2'(m));
            repeat (2) begin
                idle(10);
                expect_stall({tag, 4'h0}, 1'b1, 1'b0, c + 1, c + 1);
            end
        end
        // program/erase holds the core and empties the buffers
        c = 4;
        flash_fetch_cycle_count = 3'h4;
        set_mode(MODE_FULL);
        expect_stall({tag, 4'h0}, 1'b0, 1'b0, c + 1, c + 1);
        expect_stall({tag, 4'h4}, 1'b1, 1'b0, 0, 0);
        idle(10);
        prog_cmd = 1'b1;
        @(negedge clock);
        prog_cmd = 1'b0;
        expect_stall({tag, 4'h8}, 1'b1, 1'b0, BUSY + c - 1, BUSY + c + 2);
        // random traffic over a few lines, full mode
        idle(10);
        c = $urandom_range(1, 7);
        flash_fetch_cycle_count = 3'(c);
        idle(2);
        last = '0;
        for (int i = 0; i < 60; i++) begin
            a = {tag + 15'($urandom_range(0, 2)), 2'($urandom_range(0, 3)), 2'h0};
            if ($urandom_range(0, 3) == 0) begin
                a[ADDR_W-1:OFF_BITS] = dtag;
            end
            expect_stall(a, a == last + 19'h4, a[ADDR_W-1:OFF_BITS] == dtag, 0, 2 * c + 2);
            last = a;
            if ($urandom_range(0, 1) == 1) begin
                idle($urandom_range(1, 3));
            end
        end
        idle(4);
        complete_run();
    end
endmodule

`default_nettype wire
